// ==== core/rcs_map.svh ====
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_HALT 8'h00
`define CMD_SEND 8'h1A
`define CMD_INIT 8'h3F
// ----------------------------------------
// register offsets
// ----------------------------------------
`define A_CMD 8'h01
`define A_FIFO 8'h02
`define A_STAT 8'h03
`define A_LEVEL 8'h04
`define A_FLAGS 8'h07
`define A_PARTIAL 8'h0F
`define A_REDUND 8'h22
`define PAGE0_MASK 8'hF8
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define B_PAR_EN 0
`define B_PAR_ODD 1
`define B_CRC_EN 2
`define F_HALT 0
`define F_DONE 1
`define S_EMPTY 3
`define RST_REDUND 8'h00
`define NV_REDUND 8'h03
`define NV_PARTIAL 8'h00
`define LP_IDLE 3'h0
`define LP_WAIT 3'h1
`define LP_SOF 3'h2
`define LP_DATA 3'h3
`define LP_EOF 3'h4
`define CRC_PRESET 16'h6363
`define CRC_POLY 16'h8408
`define FIFO_DEPTH 7'h40
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 50
`define BIT_NS 9440
`define INIT_NS 10000
`endif

// ==== core/rcs_pkg.sv ====
package rcs_pkg;
   // one-hot command states
   typedef enum logic [2:0] {ST_INIT = 3'h1, ST_HALT = 3'h2, ST_SEND = 3'h4} cmd_state_t;
   // one-hot frame phases
   typedef enum logic [5:0] {
      PH_WAIT = 6'h01, PH_SOF = 6'h02, PH_DATA = 6'h04,
      PH_PAR = 6'h08, PH_CRC = 6'h10, PH_EOF = 6'h20
   } phase_t;
   // whole block state
   typedef struct packed {
      logic [63:0][7:0] mem;
      logic [5:0] wp;
      logic [5:0] rp;
      logic [6:0] cnt;
      cmd_state_t st;
      phase_t ph;
      logic [7:0] tmr;
      logic [7:0] init_cnt;
      logic [7:0] sh;
      logic [2:0] bidx;
      logic [3:0] nbits;
      logic last;
      logic acc;
      logic [15:0] crc;
      logic [3:0] cidx;
      logic tx_bit;
      logic tx_en;
      logic [7:0] rdata;
      logic [7:0] redund;
      logic [7:0] partial;
      logic halt_flag;
      logic done_flag;
      logic pin_q;
   } regs_t;
endpackage : rcs_pkg

// ==== core/reader_command_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcs_map.svh"
module reader_command_sequencer (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // reset / power-down pin, level
   input wire logic reset_powerdown_pin_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // transmitter side
   output logic tx_data_o,
   output logic tx_active_o
);
   import rcs_pkg::*;

   // ----------------------------------------
   // constants and helpers
   // ----------------------------------------
   // bit period rounds down: a longest time
   localparam logic [7:0] BIT_CYC = 8'(`BIT_NS / `CLK_NS);
   localparam logic [7:0] INIT_CYC = 8'((`INIT_NS + `CLK_NS - 1) / `CLK_NS);

   // one lsb-first crc step
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
   endfunction : crc_step

   // parity bit of a byte
   function automatic logic par_bit(input logic [7:0] b, input logic odd);
      par_bit = odd ? ~(^b) : (^b);
   endfunction : par_bit

   regs_t r_reg; // registered state
   regs_t r_next; // next state
   logic tick; // bit boundary
   logic wr_ok; // write accepted
   logic abort; // host stops a send
   logic push; // fifo write
   logic pop; // fifo read
   logic lb; // load next byte
   logic fin; // byte or parity done
   logic nb; // emitted data bit
   logic [7:0] byte_rd; // fifo head
   logic [3:0] nidx; // next bit index

   assign tick = (r_reg.tmr == 8'h00);
   assign byte_rd = r_reg.mem[r_reg.rp];
   assign nidx = {1'b0, r_reg.bidx} + 4'h1;
   // writes are dropped while init runs
   assign wr_ok = wr_i && (r_reg.st != ST_INIT);
   assign abort = wr_ok && (addr_i == `A_CMD) && (r_reg.st == ST_SEND)
                  && (wdata_i != `CMD_SEND);

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      push = 1'b0;
      pop = 1'b0;
      lb = 1'b0;
      fin = 1'b0;
      nb = 1'b0;
      r_next.pin_q = reset_powerdown_pin_i;
      // bit timer only runs inside a frame
      if (r_reg.st == ST_SEND && r_reg.ph != PH_WAIT) begin
         r_next.tmr = tick ? BIT_CYC - 8'h01 : r_reg.tmr - 8'h01;
      end
      // transmitter sequence, frozen by an abort
      if (r_reg.st == ST_SEND && !abort) begin
         case (r_reg.ph)
            PH_WAIT: begin
               // nothing sent until a byte arrives
               if (r_reg.cnt != 7'h00) begin
                  r_next.ph = PH_SOF;
                  r_next.tx_en = 1'b1;
                  r_next.tx_bit = 1'b1;
                  r_next.tmr = BIT_CYC - 8'h01;
                  r_next.crc = `CRC_PRESET;
               end
            end
            PH_SOF: begin
               if (tick) begin
                  lb = 1'b1;
               end
            end
            PH_DATA: begin
               if (tick) begin
                  if (nidx < r_reg.nbits) begin
                     nb = r_reg.sh[nidx[2:0]];
                     r_next.bidx = nidx[2:0];
                     r_next.tx_bit = nb;
                     r_next.crc = crc_step(r_reg.crc, nb);
                     // last data bit starts: sample fifo
                     if (nidx + 4'h1 == r_reg.nbits && !r_reg.redund[`B_PAR_EN]) begin
                        r_next.acc = (r_reg.cnt != 7'h00);
                     end
                  end else if (r_reg.redund[`B_PAR_EN] && !r_reg.last) begin
                     // parity is last bit, check moves here
                     r_next.ph = PH_PAR;
                     r_next.tx_bit = par_bit(r_reg.sh, r_reg.redund[`B_PAR_ODD]);
                     r_next.acc = (r_reg.cnt != 7'h00);
                  end else begin
                     fin = 1'b1;
                  end
               end
            end
            PH_PAR: begin
               if (tick) begin
                  fin = 1'b1;
               end
            end
            PH_CRC: begin
               if (tick) begin
                  if (r_reg.cidx == 4'hF) begin
                     r_next.ph = PH_EOF;
                     r_next.tx_bit = 1'b0;
                  end else begin
                     r_next.cidx = r_reg.cidx + 4'h1;
                     r_next.tx_bit = r_reg.crc[r_reg.cidx + 4'h1];
                  end
               end
            end
            PH_EOF: begin
               // frame done by itself
               if (tick) begin
                  r_next.st = ST_HALT;
                  r_next.tx_en = 1'b0;
                  r_next.tx_bit = 1'b0;
                  r_next.done_flag = 1'b1;
                  r_next.halt_flag = 1'b1;
                  r_next.partial[2:0] = 3'h0;
               end
            end
            default: begin
               r_next.ph = PH_WAIT;
            end
         endcase
         // byte over: more data, crc or eof
         if (fin) begin
            if (r_reg.acc && r_reg.cnt != 7'h00 && !r_reg.last) begin
               lb = 1'b1;
            end else if (r_reg.redund[`B_CRC_EN]) begin
               // fifo ran dry: close the frame
               r_next.ph = PH_CRC;
               r_next.cidx = 4'h0;
               r_next.tx_bit = r_reg.crc[0];
            end else begin
               r_next.ph = PH_EOF;
               r_next.tx_bit = 1'b0;
            end
         end
         // take the fifo head as the next byte
         if (lb) begin
            pop = 1'b1;
            r_next.ph = PH_DATA;
            r_next.sh = byte_rd;
            r_next.bidx = 3'h0;
            r_next.last = (r_reg.partial[2:0] != 3'h0) && (r_reg.cnt == 7'h01);
            r_next.nbits = r_next.last ? {1'b0, r_reg.partial[2:0]} : 4'h8;
            r_next.acc = (r_reg.cnt > 7'h01);
            r_next.tx_bit = byte_rd[0];
            r_next.crc = crc_step(r_reg.crc, byte_rd[0]);
         end
      end
      // register writes
      if (wr_ok) begin
         case (addr_i)
            `A_CMD: begin
               // init code is never accepted here
               if (wdata_i == `CMD_SEND && r_reg.st == ST_HALT) begin
                  r_next.st = ST_SEND;
                  r_next.ph = PH_WAIT;
                  r_next.acc = 1'b1;
               end else if (abort) begin
                  // stop now; fifo and flags untouched
                  r_next.st = ST_HALT;
                  r_next.tx_en = 1'b0;
                  r_next.tx_bit = 1'b0;
               end
            end
            `A_FIFO: begin
               if (r_reg.cnt != `FIFO_DEPTH) begin
                  push = 1'b1;
               end
            end
            `A_FLAGS: begin
               // write one clears; hardware set wins
               if (wdata_i[`F_HALT] && !(r_next.halt_flag && !r_reg.halt_flag)) begin
                  r_next.halt_flag = 1'b0;
               end
               if (wdata_i[`F_DONE] && !(r_next.done_flag && !r_reg.done_flag)) begin
                  r_next.done_flag = 1'b0;
               end
            end
            `A_REDUND: begin
               r_next.redund = wdata_i;
            end
            `A_PARTIAL: begin
               r_next.partial = wdata_i;
            end
            default: begin
               r_next.redund = r_reg.redund;
            end
         endcase
      end
      // register reads, answer next cycle
      r_next.rdata = 8'h00;
      if (rd_i && (r_reg.st != ST_INIT || (addr_i & `PAGE0_MASK) == 8'h00)) begin
         case (addr_i)
            `A_CMD: begin
               // code of the running command
               case (r_reg.st)
                  ST_INIT: r_next.rdata = `CMD_INIT;
                  ST_SEND: r_next.rdata = `CMD_SEND;
                  default: r_next.rdata = `CMD_HALT;
               endcase
            end
            `A_FIFO: begin
               r_next.rdata = byte_rd;
               // reads drain only outside a send
               if (r_reg.st != ST_SEND && r_reg.cnt != 7'h00) begin
                  pop = 1'b1;
               end
            end
            `A_STAT: begin
               r_next.rdata[`S_EMPTY] = (r_reg.cnt == 7'h00);
               if (r_reg.st != ST_SEND) begin
                  r_next.rdata[2:0] = `LP_IDLE;
               end else begin
                  case (r_reg.ph)
                     PH_WAIT: r_next.rdata[2:0] = `LP_WAIT;
                     PH_SOF: r_next.rdata[2:0] = `LP_SOF;
                     PH_EOF: r_next.rdata[2:0] = `LP_EOF;
                     default: r_next.rdata[2:0] = `LP_DATA;
                  endcase
               end
            end
            `A_LEVEL: r_next.rdata = {1'b0, r_reg.cnt};
            `A_FLAGS: r_next.rdata = {6'h00, r_reg.done_flag, r_reg.halt_flag};
            `A_REDUND: r_next.rdata = r_reg.redund;
            `A_PARTIAL: r_next.rdata = r_reg.partial;
            default: r_next.rdata = 8'h00;
         endcase
      end
      // fifo bookkeeping, never cleared by halt
      if (push) begin
         r_next.mem[r_reg.wp] = wdata_i;
         r_next.wp = r_reg.wp + 6'h01;
      end
      if (pop) begin
         r_next.rp = r_reg.rp + 6'h01;
      end
      r_next.cnt = r_reg.cnt + {6'h00, push} - {6'h00, pop};
      // init phase: wait out, then load config
      if (r_reg.st == ST_INIT) begin
         if (!reset_powerdown_pin_i) begin
            r_next.init_cnt = INIT_CYC;
         end else if (r_reg.init_cnt != 8'h00) begin
            r_next.init_cnt = r_reg.init_cnt - 8'h01;
         end else begin
            r_next.redund = `NV_REDUND;
            r_next.partial = `NV_PARTIAL;
            r_next.st = ST_HALT;
            r_next.halt_flag = 1'b1;
         end
      end
      // pin falling edge restarts init
      if (r_reg.pin_q && !reset_powerdown_pin_i) begin
         r_next.st = ST_INIT;
         r_next.init_cnt = INIT_CYC;
         r_next.tx_en = 1'b0;
         r_next.tx_bit = 1'b0;
         r_next.redund = `RST_REDUND;
         r_next.halt_flag = 1'b0;
         r_next.done_flag = 1'b0;
         r_next.wp = 6'h00;
         r_next.rp = 6'h00;
         r_next.cnt = 7'h00;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // power-on: init starts by itself
         r_reg <= '0;
         r_reg.st <= ST_INIT;
         r_reg.ph <= PH_WAIT;
         r_reg.init_cnt <= INIT_CYC;
         r_reg.redund <= `RST_REDUND;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rdata_o = r_reg.rdata;
   assign tx_data_o = r_reg.tx_bit;
   assign tx_active_o = r_reg.tx_en;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_init_run;
      r_reg.st == ST_INIT && r_reg.init_cnt != 8'h00 && reset_powerdown_pin_i;
   endsequence
   sequence s_sof_start;
      r_reg.ph == PH_SOF && r_reg.tx_en && r_reg.tx_bit;
   endsequence
   sequence s_eof_end;
      r_reg.st == ST_SEND && r_reg.ph == PH_EOF && tick && !abort && !wr_i;
   endsequence

   property p_init_holds;
      s_init_run |=> r_reg.st == ST_INIT;
   endproperty
   a_init_holds: assert property (p_init_holds) else $error("init left early");
   property p_init_to_halt;
      r_reg.st == ST_INIT && r_reg.init_cnt == 8'h00 && reset_powerdown_pin_i
         && r_reg.pin_q |=> r_reg.st == ST_HALT && r_reg.redund == `NV_REDUND;
   endproperty
   a_init_to_halt: assert property (p_init_to_halt) else $error("no halt after init");
   property p_abort_quiet;
      abort |=> r_reg.st == ST_HALT && !r_reg.tx_en && r_reg.halt_flag == $past(r_reg.halt_flag);
   endproperty
   a_abort_quiet: assert property (p_abort_quiet) else $error("abort wrong");
   property p_abort_fifo;
      abort |=> r_reg.cnt == $past(r_reg.cnt) && r_reg.rp == $past(r_reg.rp);
   endproperty
   a_abort_fifo: assert property (p_abort_fifo) else $error("abort moved fifo");
   property p_wait_empty;
      r_reg.st == ST_SEND && r_reg.ph == PH_WAIT && r_reg.cnt == 7'h00 && !wr_i
         |=> !r_reg.tx_en;
   endproperty
   a_wait_empty: assert property (p_wait_empty) else $error("sent with empty fifo");
   property p_sof_first;
      r_reg.st == ST_SEND && r_reg.ph == PH_WAIT && r_reg.cnt != 7'h00 && !wr_i
         && r_reg.pin_q |=> s_sof_start ##1 (r_reg.ph == PH_SOF)[*2];
   endproperty
   a_sof_first: assert property (p_sof_first) else $error("frame lacks sof");
   property p_done;
      s_eof_end |=> r_reg.done_flag && r_reg.halt_flag && r_reg.st == ST_HALT
         && r_reg.partial[2:0] == 3'h0 && !r_reg.tx_en;
   endproperty
   a_done: assert property (p_done) else $error("frame end wrong");
   property p_no_self_send;
      r_reg.st == ST_HALT && !(wr_i && addr_i == `A_CMD && wdata_i == `CMD_SEND)
         |=> r_reg.st != ST_SEND;
   endproperty
   a_no_self_send: assert property (p_no_self_send) else $error("send not by host");
   // writes while init counts are dropped on the floor
   property p_init_no_write;
      r_reg.st == ST_INIT && r_reg.init_cnt != 8'h00 && reset_powerdown_pin_i && wr_i
         |=> r_reg.cnt == $past(r_reg.cnt) && r_reg.redund == $past(r_reg.redund);
   endproperty
   a_init_no_write: assert property (p_init_no_write) else $error("write taken in init");
   // crc tail: late fifo bytes are kept, never popped
   property p_late_kept;
      r_reg.st == ST_SEND && r_reg.ph == PH_CRC && reset_powerdown_pin_i
         |=> r_reg.rp == $past(r_reg.rp);
   endproperty
   a_late_kept: assert property (p_late_kept) else $error("fifo popped after data");
   // halted command register reads back the halt code
   property p_cmd_read;
      rd_i && addr_i == `A_CMD && r_reg.st == ST_HALT |=> rdata_o == `CMD_HALT;
   endproperty
   a_cmd_read: assert property (p_cmd_read) else $error("command read wrong");
endmodule : reader_command_sequencer
`default_nettype wire

// ==== test/rf_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------
// bit sampler standing in for the rf transmitter
// ------
module rf_sink #(
   parameter int BIT_CYC = 188
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // serial link from the block
   input wire logic tx_data_i,
   input wire logic tx_active_i
);
   logic bits[$]; // bits of the last frame, bench clears it
   int ph; // cycle within the current bit
   // sample mid-bit, far from both bit edges, so jitter of a cycle is harmless
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph <= 0;
      end else if (!tx_active_i) begin
         ph <= 0; // re-align at every frame start
      end else begin
         ph <= (ph == BIT_CYC - 1) ? 0 : ph + 1;
         if (ph == BIT_CYC / 2) begin
            bits.push_back(tx_data_i);
         end
      end
   end
endmodule : rf_sink
`default_nettype wire

// ==== test/reader_command_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rcs_map.svh"
module reader_command_sequencer_tb;
   import rcs_pkg::*;
   // ------
   // signals
   // ------
   logic mclk_i, rst_n_i, pin, wr, rd, tx_data, tx_active;
   logic [7:0] addr, wdata, rdata, v, w;
   int err_count, checks;
   logic exp_q[$]; // expected frame bits
   logic [7:0] dq[$]; // bytes handed to the fifo
   logic [7:0] cfgs[4] = '{8'h00, 8'h01, 8'h03, 8'h07}; // parity off, even, odd, odd with crc
   localparam logic [7:0] HALT_F = 8'h01 << `F_HALT;
   localparam logic [7:0] BOTH_F = HALT_F | (8'h01 << `F_DONE);
   reader_command_sequencer dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .reset_powerdown_pin_i(pin), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .tx_data_o(tx_data), .tx_active_o(tx_active));
   rf_sink sink (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tx_data_i(tx_data),
      .tx_active_i(tx_active));
   // 20 mhz clock
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   // ------
   // bus and check tasks
   // ------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one-cycle write, a gap cycle follows so strobes never double-assign
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask : wr8
   // read data stands only in the cycle after the strobe
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd8
   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd8(a, d);
      chk(name, exp, d);
   endtask : rchk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic hang(input string name);
      err_count++;
      $display("Error %s expected done seen timeout", name);
      end_of_test();
   endtask : hang
   // host polls for the halt code before any write
   task automatic poll_halt;
      logic [7:0] d;
      d = 8'hFF;
      for (int i = 0; i < 400 && d !== `CMD_HALT; i++) rd8(`A_CMD, d);
      if (d !== `CMD_HALT) hang("poll command");
   endtask : poll_halt
   // bounded wait for a whole frame on the link
   task automatic wait_frame;
      int i;
      i = 0;
      while (tx_active !== 1'b1 && i < 100) begin
         @(posedge mclk_i);
         i++;
      end
      if (i == 100) hang("frame start");
      i = 0;
      while (tx_active === 1'b1 && i < 20000) begin
         @(posedge mclk_i);
         i++;
      end
      if (i == 20000) hang("frame end");
      repeat (3) @(posedge mclk_i);
   endtask : wait_frame
   // ------
   // expected frame: sof, lsb-first data, parity, crc, eof
   // ------
   function automatic void mk_frame(input logic [7:0] red, input logic [2:0] lb);
      logic [15:0] c;
      int n;
      c = `CRC_PRESET;
      exp_q = {1'b1};
      foreach (dq[i]) begin
         n = (i == dq.size() - 1 && lb != 3'h0) ? int'(lb) : 8; // partial only at the end
         for (int k = 0; k < n; k++) begin
            exp_q.push_back(dq[i][k]);
            c = (c >> 1) ^ ((c[0] ^ dq[i][k]) ? `CRC_POLY : 16'h0000);
         end
         if (n == 8 && red[`B_PAR_EN]) exp_q.push_back(^dq[i] ^ red[`B_PAR_ODD]);
      end
      if (red[`B_CRC_EN]) for (int k = 0; k < 16; k++) exp_q.push_back(c[k]);
      exp_q.push_back(1'b0);
   endfunction : mk_frame
   task automatic cmp_frame(input string name);
      logic bad;
      bad = (sink.bits.size() != exp_q.size());
      foreach (exp_q[i]) if (!bad && sink.bits[i] !== exp_q[i]) bad = 1'b1;
      checks++;
      if (bad) begin
         err_count++;
         $display("Error %s expected %p seen %p", name, exp_q, sink.bits);
      end
   endtask : cmp_frame
   task automatic push_rand(input int n);
      repeat (n) begin
         v = 8'($urandom);
         dq.push_back(v);
         wr8(`A_FIFO, v);
      end
   endtask : push_rand
   // prefilled frame while halted, then the send code
   task automatic send_frame(input logic [7:0] red, input logic [2:0] lb, input int n);
      dq = {};
      wr8(`A_REDUND, red);
      wr8(`A_PARTIAL, {5'h00, lb});
      push_rand(n);
      mk_frame(red, lb);
      sink.bits.delete();
      wr8(`A_CMD, `CMD_SEND);
      wait_frame();
      cmp_frame("frame");
      rchk("flags", `A_FLAGS, BOTH_F);
      rchk("command", `A_CMD, `CMD_HALT);
      rchk("partial", `A_PARTIAL, 8'h00);
      rchk("level", `A_LEVEL, 8'h00);
      wr8(`A_FLAGS, BOTH_F);
   endtask : send_frame
   // ------
   // main sequence
   // ------
   initial begin
      rst_n_i = 1'b0;
      pin = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      err_count = 0;
      checks = 0;
      void'($urandom(26339));
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // init runs by itself; host writes are refused meanwhile, page-0 reads still answer
      rchk("command", `A_CMD, `CMD_INIT);
      wr8(`A_REDUND, 8'h05);
      wr8(`A_CMD, `CMD_HALT);
      wr8(`A_FIFO, 8'hA5);
      rchk("level", `A_LEVEL, 8'h00);
      rchk("command", `A_CMD, `CMD_INIT);
      rchk("redundancy", `A_REDUND, 8'h00);
      poll_halt();
      rchk("redundancy", `A_REDUND, `NV_REDUND);
      rchk("partial", `A_PARTIAL, `NV_PARTIAL);
      rchk("flags", `A_FLAGS, HALT_F);
      wr8(`A_FLAGS, BOTH_F);
      wr8(`A_CMD, `CMD_INIT);
      rchk("command", `A_CMD, `CMD_HALT);
      wr8(`A_CMD, `CMD_HALT);
      rchk("flags", `A_FLAGS, 8'h00);
      $display("test init done");
      // fill past the brim, then drain outside send
      dq = {};
      push_rand(65);
      rchk("level", `A_LEVEL, {1'b0, `FIFO_DEPTH});
      for (int i = 0; i < 64; i++) rchk("fifo data", `A_FIFO, dq[i]);
      rchk("status", `A_STAT, (8'h01 << `S_EMPTY) | {5'h00, `LP_IDLE});
      $display("test fifo done");
      for (int i = 0; i < 4; i++) send_frame(cfgs[i], 3'h0, 1 + $urandom % 3);
      send_frame(8'h01, 3'(1 + $urandom % 7), 2);
      $display("test frames done");
      // send from an empty fifo, second byte fed while the first goes out
      dq = {};
      wr8(`A_REDUND, 8'h04);
      sink.bits.delete();
      wr8(`A_CMD, `CMD_SEND);
      rchk("status", `A_STAT, (8'h01 << `S_EMPTY) | {5'h00, `LP_WAIT});
      rchk("command", `A_CMD, `CMD_SEND);
      push_rand(1);
      repeat (40) @(posedge mclk_i);
      rd8(`A_STAT, w);
      chk("phase", {5'h00, `LP_SOF}, w & 8'h07);
      repeat (300) @(posedge mclk_i);
      rd8(`A_STAT, w);
      chk("phase", {5'h00, `LP_DATA}, w & 8'h07);
      push_rand(1);
      mk_frame(8'h04, 3'h0);
      // byte written once the crc tail runs must stay behind
      repeat (2900) @(posedge mclk_i);
      push_rand(1);
      wait_frame();
      cmp_frame("stream frame");
      rchk("level", `A_LEVEL, 8'h01);
      rchk("fifo data", `A_FIFO, dq[2]);
      rchk("flags", `A_FLAGS, BOTH_F);
      wr8(`A_FLAGS, BOTH_F);
      $display("test stream done");
      // abort in mid byte: link stops, fifo kept, no flag
      dq = {};
      wr8(`A_REDUND, 8'h01);
      push_rand(3);
      wr8(`A_CMD, `CMD_SEND);
      repeat (500) @(posedge mclk_i);
      rchk("level", `A_LEVEL, 8'h02);
      chk("link active", 8'h01, {7'h00, tx_active});
      wr8(`A_CMD, `CMD_HALT);
      #1;
      chk("link active", 8'h00, {7'h00, tx_active});
      rchk("flags", `A_FLAGS, 8'h00);
      rchk("command", `A_CMD, `CMD_HALT);
      rchk("level", `A_LEVEL, 8'h02);
      for (int i = 1; i < 3; i++) rchk("fifo data", `A_FIFO, dq[i]);
      $display("test abort done");
      // pin falling edge restarts init
      push_rand(1);
      @(posedge mclk_i);
      pin <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rchk("command", `A_CMD, `CMD_INIT);
      rchk("level", `A_LEVEL, 8'h00);
      @(posedge mclk_i);
      pin <= 1'b1;
      poll_halt();
      rchk("redundancy", `A_REDUND, `NV_REDUND);
      rchk("flags", `A_FLAGS, HALT_F);
      $display("test pin done");
      end_of_test();
   end
endmodule : reader_command_sequencer_tb
`default_nettype wire
